// File: hw/serializer_link_config_regs.sv
`timescale 1ns/10ps
module serializer_link_config_regs #(
  parameter int STEP_CYCLES = link_cfg_pkg::INIT_STEP_CYC
) (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rstn,
  // Avalon-MM slave
  input  wire logic [9:0]             i_avs_address,
  input  wire logic                   i_avs_read,
  input  wire logic                   i_avs_write,
  input  wire logic [31:0]            i_avs_writedata,
  input  wire logic [3:0]             i_avs_byteenable,
  output logic [31:0]                 o_avs_readdata,
  output logic                        o_avs_waitrequest,
  // Receive side headers and lane control
  input  wire link_cfg_pkg::pkt_hdr_t i_hdr_raw,
  input  wire link_cfg_pkg::pkt_hdr_t i_hdr_fixed,
  input  wire logic                   i_hdr_valid,
  input  wire logic                   i_hdr_interleaved,
  input  wire logic [1:0]             i_hdr_channel,
  input  wire logic [3:0]             i_lane_lp_ctrl,
  output logic [3:0]                  o_lane_lp_ctrl,
  output link_cfg_pkg::pkt_hdr_t      o_hdr_view,
  // I2C forwarding
  input  wire link_cfg_pkg::i2c_req_t i_i2c_req,
  output logic                        o_i2c_forward,
  output logic                        o_i2c_local_ack,
  output logic                        o_bc_parity_check,
  // Forward channel
  output logic                        o_sequence_crc_append,
  output logic [2:0]                  o_forward_gpio_count
);

  //==========================================================
  // Reset release
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end
  wire rst_n = rst_sync;

  //==========================================================
  // Registers
  logic [7:0] rsvd_a_reg, rsvd_b_reg, rsvd_c_reg, rsvd_d_reg;
  logic [7:0] rsvd_f_reg [3];
  logic [7:0] hdr_ctrl_reg;
  logic [7:0] bc_cfg_reg;
  logic [7:0] fwd_ctrl_reg;

  wire [7:0] idx      = i_avs_address[9:2];
  wire       wr_en    = i_avs_write && i_avs_byteenable[0] && !o_avs_waitrequest;
  wire [7:0] wdat     = i_avs_writedata[7:0];
  wire       hit_a    = (idx == link_cfg_pkg::IDX_RSVD_A);
  wire       hit_b    = (idx == link_cfg_pkg::IDX_RSVD_B);
  wire       hit_c    = (idx == link_cfg_pkg::IDX_RSVD_C);
  wire       hit_d    = (idx == link_cfg_pkg::IDX_RSVD_D);
  wire       hit_f    = (idx >= link_cfg_pkg::IDX_RSVD_F_LO) &&
                        (idx <= link_cfg_pkg::IDX_RSVD_F_HI);
  wire [1:0] f_sel    = 2'(idx - link_cfg_pkg::IDX_RSVD_F_LO);
  wire       hit_hdr  = (idx == link_cfg_pkg::IDX_HDR_CTRL);
  wire       hit_bc   = (idx == link_cfg_pkg::IDX_BC_CFG);
  wire       hit_fwd  = (idx == link_cfg_pkg::IDX_FWD_CTRL);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsvd_a_reg   <= link_cfg_pkg::RST_RSVD_A;
      rsvd_b_reg   <= link_cfg_pkg::RST_RSVD_B;
      rsvd_c_reg   <= link_cfg_pkg::RST_RSVD_C;
      rsvd_d_reg   <= link_cfg_pkg::RST_RSVD_D;
      rsvd_f_reg   <= '{default: 8'h00};
      hdr_ctrl_reg <= link_cfg_pkg::RST_HDR_CTRL;
      bc_cfg_reg   <= link_cfg_pkg::RST_BC_CFG;
      fwd_ctrl_reg <= link_cfg_pkg::RST_FWD_CTRL;
    end else if (wr_en) begin
      if (hit_a) rsvd_a_reg <= wdat & link_cfg_pkg::WM_RSVD_A;
      if (hit_b) rsvd_b_reg <= wdat & link_cfg_pkg::WM_RSVD_BCD;
      if (hit_c) rsvd_c_reg <= wdat & link_cfg_pkg::WM_RSVD_BCD;
      if (hit_d) rsvd_d_reg <= wdat & link_cfg_pkg::WM_RSVD_BCD;
      if (hit_f) rsvd_f_reg[f_sel] <= wdat;
      if (hit_hdr) hdr_ctrl_reg <= wdat;
      if (hit_bc) bc_cfg_reg <= wdat;
      if (hit_fwd) fwd_ctrl_reg <= wdat;
    end
  end

  //==========================================================
  // Lane start-up window: ignore LP control for (code+1) steps
  link_cfg_pkg::init_state_t init_state;
  logic [link_cfg_pkg::INIT_CTR_W-1:0] step_ctr;
  logic [3:0]                          step_num;
  logic [3:0]                          lp_meta, lp_sync;
  wire [3:0] steps_due = {1'b0, hdr_ctrl_reg[link_cfg_pkg::HDR_INIT_LSB +: 3]} + 4'h1;
  wire       step_tick = (step_ctr == link_cfg_pkg::INIT_CTR_W'(STEP_CYCLES - 1));
  wire       in_window = (init_state == link_cfg_pkg::INIT_WAIT);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_state <= link_cfg_pkg::INIT_WAIT;
      step_ctr   <= '0;
      step_num   <= '0;
    end else begin
      case (init_state)
        link_cfg_pkg::INIT_WAIT: begin
          step_ctr <= step_tick ? '0 : step_ctr + 1'b1;
          if (step_tick) begin
            step_num <= step_num + 4'h1;
            if (step_num + 4'h1 >= steps_due) init_state <= link_cfg_pkg::INIT_DONE;
          end
        end
        default: init_state <= link_cfg_pkg::INIT_DONE;
      endcase
    end
  end

  // Lane control arrives from the analog lanes, so resync first
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_meta        <= '0;
      lp_sync        <= '0;
      o_lane_lp_ctrl <= '0;
    end else begin
      lp_meta        <= i_lane_lp_ctrl;
      lp_sync        <= lp_meta;
      o_lane_lp_ctrl <= in_window ? 4'h0 : lp_sync;
    end
  end

  //==========================================================
  // Packet header capture, one slot per channel and per view
  link_cfg_pkg::pkt_hdr_t raw_slot [4];
  link_cfg_pkg::pkt_hdr_t fix_slot [4];
  wire       per_ch   = hdr_ctrl_reg[link_cfg_pkg::HDR_REC_BIT];
  wire [1:0] wr_slot  = (per_ch && i_hdr_interleaved) ? i_hdr_channel : 2'd0;
  wire [1:0] rd_slot  = per_ch ? hdr_ctrl_reg[link_cfg_pkg::HDR_VC_LSB +: 2] : 2'd0;
  wire       fix_view = hdr_ctrl_reg[link_cfg_pkg::HDR_VIEW_BIT];

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_slot   <= '{default: '0};
      fix_slot   <= '{default: '0};
      o_hdr_view <= '0;
    end else begin
      if (i_hdr_valid) begin
        raw_slot[wr_slot] <= i_hdr_raw;
        fix_slot[wr_slot] <= i_hdr_fixed;
      end
      o_hdr_view <= fix_view ? fix_slot[rd_slot] : raw_slot[rd_slot];
    end
  end

  //==========================================================
  // I2C forwarding and forward path controls
  wire fwd_all   = bc_cfg_reg[link_cfg_pkg::BC_ALL_BIT];
  wire fwd_match = bc_cfg_reg[link_cfg_pkg::BC_MATCH_BIT];
  wire auto_ack  = bc_cfg_reg[link_cfg_pkg::BC_ACK_BIT];
  wire [1:0] gpio_code = fwd_ctrl_reg[link_cfg_pkg::FWD_GPIO_LSB +: 2];
  wire [2:0] gpio_n    = (gpio_code == 2'b11) ? 3'd4 : {1'b0, gpio_code};

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_i2c_forward         <= 1'b0;
      o_i2c_local_ack       <= 1'b0;
      o_bc_parity_check     <= 1'b1;
      o_sequence_crc_append <= 1'b1;
      o_forward_gpio_count  <= '0;
    end else begin
      o_i2c_forward <= i_i2c_req.valid &&
                       (fwd_all || (fwd_match && i_i2c_req.addr_match));
      o_i2c_local_ack       <= i_i2c_req.valid && i_i2c_req.is_write && auto_ack;
      o_bc_parity_check     <= bc_cfg_reg[link_cfg_pkg::BC_PAR_BIT];
      o_sequence_crc_append <= fwd_ctrl_reg[link_cfg_pkg::FWD_CRC_BIT];
      o_forward_gpio_count  <= gpio_n;
    end
  end

  //==========================================================
  // Bus answer: one wait cycle, then data with waitrequest low
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_a) rd_byte = rsvd_a_reg;
    else if (hit_b) rd_byte = rsvd_b_reg;
    else if (hit_c) rd_byte = rsvd_c_reg;
    else if (hit_d) rd_byte = rsvd_d_reg;
    else if (hit_f) rd_byte = rsvd_f_reg[f_sel];
    else if (hit_hdr) rd_byte = hdr_ctrl_reg;
    else if (hit_bc) rd_byte = bc_cfg_reg;
    else if (hit_fwd) rd_byte = fwd_ctrl_reg;
    else if (idx == link_cfg_pkg::IDX_STATUS) rd_byte = {7'h00, in_window};
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= '0;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest) o_avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  //==========================================================
  // Window length monitor for the checks; 16 bits hold eight default steps
  localparam int MAX_STEPS = 1 << 3; // Three-bit code, so eight steps at most
  logic [15:0] win_cyc;
  wire  [31:0] win_min = 32'(steps_due) * 32'(STEP_CYCLES);
  wire  [31:0] win_max = 32'(MAX_STEPS * STEP_CYCLES);
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      win_cyc <= 16'h0000;
    end else if (in_window) begin
      win_cyc <= win_cyc + 16'h0001;
    end
  end

  //==========================================================
  // Checks
  property p_win_min;
    @(posedge i_clk) disable iff (!rst_n)
    $fell(in_window) |-> (32'(win_cyc) >= win_min);
  endproperty
  a_win_min: assert property (p_win_min) else $error("start-up window too short");

  property p_win_max;
    @(posedge i_clk) disable iff (!rst_n)
    in_window |-> (32'(win_cyc) < win_max);
  endproperty
  a_win_max: assert property (p_win_max) else $error("start-up window too long");

  property p_rec_flat;
    @(posedge i_clk) disable iff (!rst_n)
    (i_hdr_valid && !(per_ch && i_hdr_interleaved)) |=> (raw_slot[0] == $past(i_hdr_raw));
  endproperty
  a_rec_flat: assert property (p_rec_flat) else $error("flat header not in slot zero");

  property p_rec_chan;
    @(posedge i_clk) disable iff (!rst_n)
    (i_hdr_valid && per_ch && i_hdr_interleaved) |=>
    (fix_slot[$past(i_hdr_channel)] == $past(i_hdr_fixed));
  endproperty
  a_rec_chan: assert property (p_rec_chan) else $error("header not in its channel slot");

  property p_sel_off;
    @(posedge i_clk) disable iff (!rst_n)
    (!per_ch && fix_view) |=> (o_hdr_view == $past(fix_slot[0]));
  endproperty
  a_sel_off: assert property (p_sel_off) else $error("channel select used while off");

  property p_view_raw;
    @(posedge i_clk) disable iff (!rst_n)
    (!fix_view && $stable(rd_slot)) |=> (o_hdr_view == $past(raw_slot[rd_slot]));
  endproperty
  a_view_raw: assert property (p_view_raw) else $error("raw header view wrong");

  property p_fwd_idle;
    @(posedge i_clk) disable iff (!rst_n)
    !i_i2c_req.valid |=> !o_i2c_forward;
  endproperty
  a_fwd_idle: assert property (p_fwd_idle) else $error("forward without request");

  property p_fwd_hit;
    @(posedge i_clk) disable iff (!rst_n)
    (i_i2c_req.valid && fwd_match && i_i2c_req.addr_match) |=> o_i2c_forward;
  endproperty
  a_fwd_hit: assert property (p_fwd_hit) else $error("matched forward missed");

  property p_ack_off;
    @(posedge i_clk) disable iff (!rst_n)
    !(i_i2c_req.valid && i_i2c_req.is_write && auto_ack) |=> !o_i2c_local_ack;
  endproperty
  a_ack_off: assert property (p_ack_off) else $error("spurious local ack");

  property p_gpio_low;
    @(posedge i_clk) disable iff (!rst_n)
    (gpio_code != 2'b11) |=> (o_forward_gpio_count == {1'b0, $past(gpio_code)});
  endproperty
  a_gpio_low: assert property (p_gpio_low) else $error("low gpio count wrong");

  property p_lp_blocked;
    @(posedge i_clk) disable iff (!rst_n)
    in_window |=> (o_lane_lp_ctrl == 4'h0);
  endproperty
  a_lp_blocked: assert property (p_lp_blocked) else $error("lane ctrl leaked");

  property p_view_sel;
    @(posedge i_clk) disable iff (!rst_n)
    (fix_view && $stable(rd_slot)) |=> (o_hdr_view == $past(fix_slot[rd_slot]));
  endproperty
  a_view_sel: assert property (p_view_sel) else $error("wrong header view");

  property p_fwd_all;
    @(posedge i_clk) disable iff (!rst_n)
    (i_i2c_req.valid && fwd_all) |=> o_i2c_forward;
  endproperty
  a_fwd_all: assert property (p_fwd_all) else $error("forward-all missed");

  property p_fwd_match;
    @(posedge i_clk) disable iff (!rst_n)
    (!fwd_all && !(fwd_match && i_i2c_req.addr_match)) |=> !o_i2c_forward;
  endproperty
  a_fwd_match: assert property (p_fwd_match) else $error("bad forward");

  property p_ack;
    @(posedge i_clk) disable iff (!rst_n)
    (i_i2c_req.valid && i_i2c_req.is_write && auto_ack) |=> o_i2c_local_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("auto ack missed");

  sequence s_bc_wr;
    wr_en && hit_bc;
  endsequence
  property p_par;
    @(posedge i_clk) disable iff (!rst_n)
    s_bc_wr |=> ##1 (o_bc_parity_check == $past(wdat[link_cfg_pkg::BC_PAR_BIT], 2));
  endproperty
  a_par: assert property (p_par) else $error("parity enable wrong");

  sequence s_fwd_wr;
    wr_en && hit_fwd;
  endsequence
  property p_crc;
    @(posedge i_clk) disable iff (!rst_n)
    s_fwd_wr |=> ##1 (o_sequence_crc_append == $past(wdat[link_cfg_pkg::FWD_CRC_BIT], 2));
  endproperty
  a_crc: assert property (p_crc) else $error("crc enable wrong");

  property p_gpio;
    @(posedge i_clk) disable iff (!rst_n)
    (gpio_code == 2'b11) |=> (o_forward_gpio_count == 3'd4);
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio count wrong");

  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  property p_bus;
    @(posedge i_clk) disable iff (!rst_n)
    s_req |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer timing");

endmodule : serializer_link_config_regs

// File: hw/link_cfg_pkg.sv
//==========================================================
// Notes on behaviour
// - Ignore lane LP signalling for 100us times (code+1)
// - Enable bit records headers per virtual channel
// - Channel select applies only when recording enabled
// - Header view selector resets to one
// - Forward-all passes every I2C transaction across
// - Address-match bit forwards only decoded transactions
// - Auto-ack acknowledges every I2C write locally
// - Parity check enable resets to one
// - Sequence CRC over eight bytes, sent ninth
// - GPIO count field: 0,1,2,4 forwarded GPIOs
package link_cfg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RSVD_A    = 8'h27;
  localparam logic [7:0] IDX_RSVD_B    = 8'h28;
  localparam logic [7:0] IDX_RSVD_C    = 8'h29;
  localparam logic [7:0] IDX_RSVD_D    = 8'h2A;
  localparam logic [7:0] IDX_RSVD_E_LO = 8'h2B;
  localparam logic [7:0] IDX_RSVD_E_HI = 8'h2D;
  localparam logic [7:0] IDX_RSVD_F_LO = 8'h2E;
  localparam logic [7:0] IDX_RSVD_F_HI = 8'h30;
  localparam logic [7:0] IDX_HDR_CTRL  = 8'h31;
  localparam logic [7:0] IDX_BC_CFG    = 8'h32;
  localparam logic [7:0] IDX_FWD_CTRL  = 8'h33;
  localparam logic [7:0] IDX_STATUS    = 8'h3F;

  // Reset values
  localparam logic [7:0] RST_RSVD_A   = 8'h00;
  localparam logic [7:0] RST_RSVD_B   = 8'h07;
  localparam logic [7:0] RST_RSVD_C   = 8'h33;
  localparam logic [7:0] RST_RSVD_D   = 8'h01;
  localparam logic [7:0] RST_HDR_CTRL = 8'h20;
  localparam logic [7:0] RST_BC_CFG   = 8'h09;
  localparam logic [7:0] RST_FWD_CTRL = 8'h04;

  // Writable masks; other bits read as stored reset value or zero
  localparam logic [7:0] WM_RSVD_A    = 8'h07;
  localparam logic [7:0] WM_RSVD_BCD  = 8'h77;
  localparam logic [7:0] WM_FULL      = 8'hFF;

  // Field positions
  localparam int HDR_INIT_LSB = 0;
  localparam int HDR_REC_BIT  = 4;
  localparam int HDR_VIEW_BIT = 5;
  localparam int HDR_VC_LSB   = 6;
  localparam int BC_PAR_BIT   = 3;
  localparam int BC_ACK_BIT   = 5;
  localparam int BC_MATCH_BIT = 6;
  localparam int BC_ALL_BIT   = 7;
  localparam int FWD_GPIO_LSB = 0;
  localparam int FWD_CRC_BIT  = 2;

  // Lane start-up ignore window
  localparam int CLK_HZ          = 50_000_000;
  localparam int INIT_STEP_US    = 100;
  localparam int INIT_STEP_CYC   = (INIT_STEP_US * (CLK_HZ / 1_000_000));
  localparam int INIT_CTR_W      = 13;
  localparam logic [3:0] SEQ_CRC_POS = 4'h8;

  // Captured packet header: data id, word count, ecc
  typedef struct packed {
    logic [7:0]  data_id;
    logic [15:0] word_count;
    logic [7:0]  ecc;
  } pkt_hdr_t;

  // I2C forwarding request from the local slave
  typedef struct packed {
    logic valid;
    logic addr_match;
    logic is_write;
  } i2c_req_t;

  typedef enum logic [1:0] { INIT_WAIT, INIT_DONE } init_state_t;

endpackage : link_cfg_pkg

// File: testbench/hdr_source_model.sv
`timescale 1ns/10ps
//==========================================================
// Imager-side header source; lines toggle between packets so a stale value never matches
module hdr_source_model (
  // From bench
  input  wire logic                   i_clk,
  input  wire logic                   i_send,
  input  wire logic [1:0]             i_ch,
  input  wire link_cfg_pkg::pkt_hdr_t i_raw,
  input  wire link_cfg_pkg::pkt_hdr_t i_fixed,
  // Toward the design
  output link_cfg_pkg::pkt_hdr_t      o_raw,
  output link_cfg_pkg::pkt_hdr_t      o_fixed,
  output logic                        o_valid,
  output logic [1:0]                  o_ch
);
  always_ff @(posedge i_clk) begin
    o_valid <= i_send;
    o_ch    <= i_ch;
    o_raw   <= i_send ? i_raw : ~o_raw;
    o_fixed <= i_send ? i_fixed : ~o_fixed;
  end
endmodule : hdr_source_model

// File: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic [7:0] bc;
    logic [7:0] fwd;
    logic [2:0] req;
    logic       e_fwd;
    logic       e_ack;
    logic [2:0] e_gpio;
  } row_t;
  //==========================================================
  // Rows: back channel, forward control, request, forward, ack, gpio count
  localparam row_t ROWS [8] = '{
    '{8'h80, 8'h00, 3'h4, 1'h1, 1'h0, 3'h0}, '{8'h40, 8'h01, 3'h6, 1'h1, 1'h0, 3'h1},
    '{8'h40, 8'h02, 3'h4, 1'h0, 1'h0, 3'h2}, '{8'h20, 8'h03, 3'h5, 1'h0, 1'h1, 3'h4},
    '{8'h20, 8'h07, 3'h4, 1'h0, 1'h0, 3'h4}, '{8'h28, 8'h04, 3'h3, 1'h0, 1'h0, 3'h0},
    '{8'h00, 8'h00, 3'h7, 1'h0, 1'h0, 3'h0}, '{8'hE8, 8'h05, 3'h7, 1'h1, 1'h1, 3'h1}};
  logic                   clk = 1'b0;
  logic                   rstn = 1'b0;
  logic [9:0]             adr = 10'h000;
  logic                   rd_en = 1'b0;
  logic                   wr_en = 1'b0;
  logic [31:0]            wdata = 32'h0000_0000;
  logic [31:0]            rdata;
  logic                   waitreq;
  logic                   send = 1'b0;
  logic [1:0]             sch = 2'h0;
  link_cfg_pkg::pkt_hdr_t sraw = '0;
  link_cfg_pkg::pkt_hdr_t sfix = '0;
  link_cfg_pkg::pkt_hdr_t hraw, hfix, view;
  logic                   hvalid;
  logic [1:0]             hch;
  logic [3:0]             lp_out;
  link_cfg_pkg::i2c_req_t req = '0;
  logic                   fwd_o, ack_o, par_o, crc_o;
  logic [2:0]             gpio_o;
  logic [3:0]             lp_in = 4'hA;
  logic                   ilv = 1'b1;
  logic [3:0]             be = 4'hF;
  logic [7:0]             junk;
  int                     errors = 0;
  int                     samples_checked = 0;

  always #10 clk = ~clk;

  serializer_link_config_regs #(.STEP_CYCLES(10)) DUT (.i_clk(clk), .i_rstn(rstn),
    .i_avs_address(adr), .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_hdr_raw(hraw), .i_hdr_fixed(hfix), .i_hdr_valid(hvalid), .i_hdr_interleaved(ilv),
    .i_hdr_channel(hch), .i_lane_lp_ctrl(lp_in), .o_lane_lp_ctrl(lp_out), .o_hdr_view(view),
    .i_i2c_req(req), .o_i2c_forward(fwd_o), .o_i2c_local_ack(ack_o),
    .o_bc_parity_check(par_o), .o_sequence_crc_append(crc_o), .o_forward_gpio_count(gpio_o));
  hdr_source_model model (.i_clk(clk), .i_send(send), .i_ch(sch), .i_raw(sraw),
    .i_fixed(sfix), .o_raw(hraw), .o_fixed(hfix), .o_valid(hvalid), .o_ch(hch));

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Request held until the rising edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    adr   <= {idx, 2'h0};
    wr_en <= wr;
    rd_en <= ~wr;
    wdata <= {24'h00_0000, wd};
    @(posedge clk);
    while (waitreq !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (waitreq !== 1'b0) begin
      errors++;
      report_and_stop();
    end
    rd = rdata[7:0];
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, junk);
  endtask : wr

  task automatic rdc(input string name, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    bus(1'b0, idx, 8'h00, v);
    chk(name, 32'(v), 32'(exp));
  endtask : rdc

  function automatic link_cfg_pkg::pkt_hdr_t hdr_of(input logic fix, input int k);
    return link_cfg_pkg::pkt_hdr_t'((fix ? 32'h2000_00AA : 32'h1000_0055) | (k << 24));
  endfunction : hdr_of

  initial begin
    repeat (10) @(posedge clk);
    chk("wait_rst", waitreq, 1);
    chk("par_rst", par_o, 1);
    chk("crc_rst", crc_o, 1);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("lp_early", lp_out, 0);
    rdc("status", link_cfg_pkg::IDX_STATUS, 8'h01);
    rdc("hdr_rst", link_cfg_pkg::IDX_HDR_CTRL, 8'h20);
    rdc("bc_rst", link_cfg_pkg::IDX_BC_CFG, 8'h09);
    rdc("fwd_rst", link_cfg_pkg::IDX_FWD_CTRL, 8'h04);
    repeat (10) @(posedge clk);
    chk("lp_late", lp_out, 32'hA);
    wr(8'h27, 8'hFF);
    rdc("rsv27", 8'h27, 8'h07);
    wr(8'h28, 8'hFF);
    rdc("rsv28", 8'h28, 8'h77);
    wr(8'h2C, 8'hFF);
    rdc("rsv2c", 8'h2C, 8'h00);
    wr(8'h2F, 8'hA5);
    rdc("rsv2f", 8'h2F, 8'hA5);
    be <= 4'hE;
    wr(8'h2E, 8'h3C);
    be <= 4'hF;
    rdc("rsv2e_be", 8'h2E, 8'h00);
    rdc("unmapped", 8'h40, 8'h00);
    $display("test reset and registers done");
    foreach (ROWS[i]) begin
      wr(link_cfg_pkg::IDX_BC_CFG, ROWS[i].bc);
      wr(link_cfg_pkg::IDX_FWD_CTRL, ROWS[i].fwd);
      rdc("bc", link_cfg_pkg::IDX_BC_CFG, ROWS[i].bc);
      @(posedge clk);
      req <= ROWS[i].req;
      @(posedge clk);
      req <= '0;
      @(negedge clk);
      chk("forward", fwd_o, ROWS[i].e_fwd);
      chk("ack", ack_o, ROWS[i].e_ack);
      chk("gpio", gpio_o, ROWS[i].e_gpio);
      chk("crc", crc_o, ROWS[i].fwd[2]);
      chk("parity", par_o, ROWS[i].bc[3]);
    end
    $display("test forwarding rows done");
    wr(link_cfg_pkg::IDX_HDR_CTRL, 8'h30);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      send <= 1'b1;
      sch  <= k[1:0];
      sraw <= hdr_of(1'b0, k);
      sfix <= hdr_of(1'b1, k);
      @(posedge clk);
      send <= 1'b0;
    end
    for (int k = 0; k < 4; k++) begin
      for (int v = 0; v < 2; v++) begin
        wr(link_cfg_pkg::IDX_HDR_CTRL, {k[1:0], v[0], 5'h10});
        repeat (2) @(posedge clk);
        chk("view", view, hdr_of(v[0], k));
      end
    end
    // Recording off: channel select must be ignored, slot zero shown
    wr(link_cfg_pkg::IDX_HDR_CTRL, 8'hE0);
    repeat (2) @(posedge clk);
    chk("view_off", view, hdr_of(1'b1, 0));
    // Non-interleaved traffic lands in slot zero whatever its channel
    wr(link_cfg_pkg::IDX_HDR_CTRL, 8'h10);
    @(posedge clk);
    send <= 1'b1;
    ilv  <= 1'b0;
    sch  <= 2'h2;
    sraw <= hdr_of(1'b0, 5);
    sfix <= hdr_of(1'b1, 5);
    @(posedge clk);
    send <= 1'b0;
    repeat (3) @(posedge clk);
    chk("view_flat", view, hdr_of(1'b0, 5));
    wr(link_cfg_pkg::IDX_HDR_CTRL, 8'h90);
    repeat (2) @(posedge clk);
    chk("view_ch2", view, hdr_of(1'b0, 2));
    ilv <= 1'b1;
    $display("test headers done");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    lp_in <= 4'h5;
    repeat (3) @(posedge clk);
    wr(link_cfg_pkg::IDX_HDR_CTRL, 8'h23);
    repeat (20) @(posedge clk);
    chk("lp_win", lp_out, 0);
    rdc("status_win", link_cfg_pkg::IDX_STATUS, 8'h01);
    rdc("bc_rst2", link_cfg_pkg::IDX_BC_CFG, 8'h09);
    repeat (30) @(posedge clk);
    chk("lp_open", lp_out, 32'h5);
    rdc("status_end", link_cfg_pkg::IDX_STATUS, 8'h00);
    $display("test start-up window done");
    report_and_stop();
  end
endmodule : testbench
